// ---- include/tct_pkg.sv ----
package tct_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;
    localparam int NUM_OSC = 4;
    localparam int NUM_TIMER = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] TONE1_CONTROL_OFS = 8'h20;
    localparam logic [7:0] TONE2_CONTROL_OFS = 8'h21;
    localparam logic [7:0] RING_CONTROL_OFS = 8'h22;
    localparam logic [7:0] PULSE_METER_CONTROL_OFS = 8'h23;
    localparam logic [7:0] TONE1_ON_TIME_LOW_OFS = 8'h24;
    localparam logic [7:0] TONE1_ON_TIME_HIGH_OFS = 8'h25;
    localparam logic [7:0] TONE1_OFF_TIME_LOW_OFS = 8'h26;
    localparam logic [7:0] TONE1_OFF_TIME_HIGH_OFS = 8'h27;
    localparam logic [7:0] TONE2_ON_TIME_LOW_OFS = 8'h28;
    localparam logic [7:0] TONE2_ON_TIME_HIGH_OFS = 8'h29;
    localparam logic [7:0] TONE2_OFF_TIME_LOW_OFS = 8'h2A;
    localparam logic [7:0] TONE2_OFF_TIME_HIGH_OFS = 8'h2B;
    localparam logic [7:0] METER_ON_TIME_LOW_OFS = 8'h2C;
    localparam logic [7:0] METER_ON_TIME_HIGH_OFS = 8'h2D;
    localparam logic [7:0] METER_OFF_TIME_LOW_OFS = 8'h2E;
    localparam logic [7:0] METER_OFF_TIME_HIGH_OFS = 8'h2F;
    localparam logic [7:0] RING_ON_TIME_LOW_OFS = 8'h30;
    localparam logic [7:0] RING_ON_TIME_HIGH_OFS = 8'h31;
    localparam logic [7:0] RING_OFF_TIME_LOW_OFS = 8'h32;
    localparam logic [7:0] RING_OFF_TIME_HIGH_OFS = 8'h33;
    localparam logic [7:0] TIMER_LAST_OFS = 8'h33;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_STATUS_BIT = 7;
    localparam int CTRL_ON_TIMER_BIT = 4;
    localparam int CTRL_OFF_TIMER_BIT = 3;
    localparam int CTRL_OSC_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] TIME_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator indices
    localparam int OSC_TONE1 = 0;
    localparam int OSC_TONE2 = 1;
    localparam int OSC_RING = 2;
    localparam int OSC_METER = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 125;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

endpackage

// ---- logic/tct_cadence.sv ----
`timescale 1ns/100ps
module tct_cadence
    import tct_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int CNT_W = COUNT_W
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic osc_enable_i,
    input wire logic on_timer_enable_i,
    input wire logic off_timer_enable_i,
    input wire logic [CNT_W-1:0] on_count_i,
    input wire logic [CNT_W-1:0] off_count_i,
    output logic signal_active_o
);

    initial begin
        if (TICK_LEN < 2 || CNT_W < 1) begin
            $error("tct_cadence: unsupported parameters");
        end
    end

    typedef enum logic [1:0] {
        CAD_IDLE = 2'b00,
        CAD_ON = 2'b01,
        CAD_OFF = 2'b10,
        CAD_HOLD = 2'b11
    } tct_cad_state_t;

    localparam int PRE_W = $clog2(TICK_LEN);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_LEN - 1);

    tct_cad_state_t state_reg;
    tct_cad_state_t state_next;
    logic [PRE_W-1:0] pre_reg;
    logic [CNT_W-1:0] elapsed_reg;
    logic tick;
    logic on_done;
    logic off_done;

    ////////////////////////////////////////////////////////////////////////////
    // 125 us tick, held at zero until the first interval is entered
    // Starting it with the active output keeps the first interval full length
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg <= '0;
        end else if (!osc_enable_i || state_reg == CAD_IDLE || pre_reg == PRE_LAST) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    assign tick = (pre_reg == PRE_LAST);
    // Zero count acts as one tick
    assign on_done = tick && (elapsed_reg + 1'b1 >= on_count_i);
    assign off_done = tick && (elapsed_reg + 1'b1 >= off_count_i);

    ////////////////////////////////////////////////////////////////////////////
    // Interval sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CAD_IDLE: if (osc_enable_i) state_next = CAD_ON;
            CAD_ON: begin
                if (on_timer_enable_i && on_done) begin
                    state_next = off_timer_enable_i ? CAD_OFF : CAD_HOLD;
                end
            end
            CAD_OFF: if (off_done) state_next = on_timer_enable_i ? CAD_ON : CAD_HOLD;
            CAD_HOLD: state_next = CAD_HOLD;
        endcase
        if (!osc_enable_i) begin
            state_next = CAD_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= CAD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Elapsed ticks within current interval
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            elapsed_reg <= '0;
        end else if (state_next != state_reg) begin
            elapsed_reg <= '0;
        end else if (tick) begin
            elapsed_reg <= elapsed_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active only in the on interval
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            signal_active_o <= 1'b0;
        end else begin
            signal_active_o <= (state_next == CAD_ON);
        end
    end

endmodule

// ---- logic/tct_top.sv ----
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module tct_top
    import tct_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic tone1_active_o,
    output logic tone2_active_o,
    output logic ring_active_o,
    output logic meter_signal_active_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    initial begin
        if (TICK_LEN < 2) begin
            $error("tct_top: tick length too short");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [2:0] ctrl_reg [NUM_OSC];
    logic [DATA_W-1:0] time_low_reg [NUM_TIMER];
    logic [DATA_W-1:0] time_high_reg [NUM_TIMER];
    logic [COUNT_W-1:0] time_count [NUM_TIMER];
    logic [NUM_OSC-1:0] osc_active;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic ctrl_hit;
    logic timer_hit;
    logic [ADDR_W-1:0] ctrl_ofs;
    logic [ADDR_W-1:0] timer_ofs;
    logic [1:0] ctrl_sel;
    logic [2:0] timer_sel;
    logic timer_high_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign ctrl_ofs = addr_i - TONE1_CONTROL_OFS;
    assign timer_ofs = addr_i - TONE1_ON_TIME_LOW_OFS;
    assign ctrl_hit = (addr_i >= TONE1_CONTROL_OFS) && (addr_i <= PULSE_METER_CONTROL_OFS);
    assign timer_hit = (addr_i >= TONE1_ON_TIME_LOW_OFS) && (addr_i <= TIMER_LAST_OFS);
    assign ctrl_sel = ctrl_ofs[1:0];
    assign timer_sel = timer_ofs[3:1];
    assign timer_high_sel = timer_ofs[0];

    ////////////////////////////////////////////////////////////////////////////
    // Control registers, one per oscillator
    // Bits held as {on timer enable, off timer enable, oscillator enable}
    generate
        for (genvar c = 0; c < NUM_OSC; c++) begin : g_ctrl
            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    ctrl_reg[c] <= CTRL_RESET;
                end else if (write_i && ctrl_hit && ctrl_sel == 2'(c)) begin
                    ctrl_reg[c] <= {wdata_i[CTRL_ON_TIMER_BIT],
                                    wdata_i[CTRL_OFF_TIMER_BIT],
                                    wdata_i[CTRL_OSC_BIT]};
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Timer byte registers, low and high byte per count
    generate
        for (genvar t = 0; t < NUM_TIMER; t++) begin : g_timer
            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    time_low_reg[t] <= TIME_RESET;
                end else if (write_i && timer_hit && timer_sel == 3'(t) && !timer_high_sel) begin
                    time_low_reg[t] <= wdata_i;
                end
            end

            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    time_high_reg[t] <= TIME_RESET;
                end else if (write_i && timer_hit && timer_sel == 3'(t) && timer_high_sel) begin
                    time_high_reg[t] <= wdata_i;
                end
            end

            // High byte carries bits 15:8
            assign time_count[t] = {time_high_reg[t], time_low_reg[t]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Cadence engines
    // Timer pairs are laid out tone1, tone2, meter, ring
    tct_cadence #(
        .TICK_LEN(TICK_LEN),
        .CNT_W(COUNT_W)
    ) u_tone1 (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .osc_enable_i(ctrl_reg[OSC_TONE1][0]),
        .on_timer_enable_i(ctrl_reg[OSC_TONE1][2]),
        .off_timer_enable_i(ctrl_reg[OSC_TONE1][1]),
        .on_count_i(time_count[0]),
        .off_count_i(time_count[1]),
        .signal_active_o(osc_active[OSC_TONE1])
    );

    tct_cadence #(
        .TICK_LEN(TICK_LEN),
        .CNT_W(COUNT_W)
    ) u_tone2 (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .osc_enable_i(ctrl_reg[OSC_TONE2][0]),
        .on_timer_enable_i(ctrl_reg[OSC_TONE2][2]),
        .off_timer_enable_i(ctrl_reg[OSC_TONE2][1]),
        .on_count_i(time_count[2]),
        .off_count_i(time_count[3]),
        .signal_active_o(osc_active[OSC_TONE2])
    );

    tct_cadence #(
        .TICK_LEN(TICK_LEN),
        .CNT_W(COUNT_W)
    ) u_meter (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .osc_enable_i(ctrl_reg[OSC_METER][0]),
        .on_timer_enable_i(ctrl_reg[OSC_METER][2]),
        .off_timer_enable_i(ctrl_reg[OSC_METER][1]),
        .on_count_i(time_count[4]),
        .off_count_i(time_count[5]),
        .signal_active_o(osc_active[OSC_METER])
    );

    tct_cadence #(
        .TICK_LEN(TICK_LEN),
        .CNT_W(COUNT_W)
    ) u_ring (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .osc_enable_i(ctrl_reg[OSC_RING][0]),
        .on_timer_enable_i(ctrl_reg[OSC_RING][2]),
        .off_timer_enable_i(ctrl_reg[OSC_RING][1]),
        .on_count_i(time_count[6]),
        .off_count_i(time_count[7]),
        .signal_active_o(osc_active[OSC_RING])
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; reserved bits and unmapped offsets read zero
    always_comb begin
        rdata_next = READ_ZERO;
        if (read_i && ctrl_hit) begin
            rdata_next[CTRL_STATUS_BIT] = osc_active[ctrl_sel];
            rdata_next[CTRL_ON_TIMER_BIT] = ctrl_reg[ctrl_sel][2];
            rdata_next[CTRL_OFF_TIMER_BIT] = ctrl_reg[ctrl_sel][1];
            rdata_next[CTRL_OSC_BIT] = ctrl_reg[ctrl_sel][0];
        end else if (read_i && timer_hit) begin
            rdata_next = timer_high_sel ? time_high_reg[timer_sel] : time_low_reg[timer_sel];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data stand one cycle after the strobe only
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= READ_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_o = rdata_reg;
    assign tone1_active_o = osc_active[OSC_TONE1];
    assign tone2_active_o = osc_active[OSC_TONE2];
    assign ring_active_o = osc_active[OSC_RING];
    assign meter_signal_active_o = osc_active[OSC_METER];

endmodule

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb
    import tct_pkg::*;
;
    localparam int TL = 4;
    logic core_clk_i;
    logic nrst_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic write_i;
    logic read_i;
    logic [DATA_W-1:0] rdata_o;
    logic [3:0] act;
    int error_cnt;
    int n_compared;
    logic [7:0] tbase [4] = '{8'h24, 8'h28, 8'h30, 8'h2C};

    tct_top #(.TICK_LEN(TL)) DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
        .tone1_active_o(act[0]), .tone2_active_o(act[1]), .ring_active_o(act[2]),
        .meter_signal_active_o(act[3]));

    // Clock at 10 MHz
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkn(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            error_cnt++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge core_clk_i);
        write_i <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge core_clk_i);
        read_i <= 1'b0;
        @(negedge core_clk_i);
        chk("rdata", e, rdata_o);
    endtask
    // Cycles that an output holds the given level
    task automatic run(input int i, input logic lv, output int n);
        n = 0;
        while (act[i] === lv && n < 5000) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 8'h20; a <= 8'h34; a++) rc(a[7:0], 8'h00);
    endtask
    task automatic t_regs();
        for (int a = 8'h24; a <= 8'h33; a++) wr(a[7:0], a[7:0] ^ 8'hA5);
        for (int a = 8'h24; a <= 8'h33; a++) rc(a[7:0], a[7:0] ^ 8'hA5);
        wr(8'h23, 8'hFB);
        rc(8'h23, 8'h18);
    endtask
    task automatic t_cad(input int i, input logic [15:0] on, input logic [7:0] off);
        int n;
        wr(tbase[i], on[7:0]);
        wr(tbase[i] + 8'h1, on[15:8]);
        wr(tbase[i] + 8'h2, off);
        wr(tbase[i] + 8'h3, 8'h00);
        wr(8'h20 + i[7:0], 8'h1C);
        @(negedge core_clk_i);
        run(i, 1'b0, n);
        run(i, 1'b1, n);
        chkn("on time", on * TL, n);
        run(i, 1'b0, n);
        chkn("off time", off * TL, n);
        run(i, 1'b1, n);
        chkn("on time", on * TL, n);
        if (i == OSC_METER) rc(8'h23, 8'h1C);
        wr(8'h20 + i[7:0], 8'h00);
        repeat (2) @(negedge core_clk_i);
        chk("active", 8'h00, {7'h0, act[i]});
    endtask
    task automatic t_noon();
        wr(8'h23, 8'h0C);
        repeat (40) @(negedge core_clk_i);
        chk("active", 8'h01, {7'h0, act[3]});
        rc(8'h23, 8'h8C);
        wr(8'h23, 8'h00);
        repeat (2) @(negedge core_clk_i);
        chk("active", 8'h00, {7'h0, act[3]});
        rc(8'h23, 8'h00);
    endtask
    task automatic t_nooff();
        int n;
        wr(8'h2C, 8'h02);
        wr(8'h2D, 8'h00);
        wr(8'h23, 8'h14);
        @(negedge core_clk_i);
        run(3, 1'b0, n);
        run(3, 1'b1, n);
        chkn("on time", 2 * TL, n);
        repeat (40) @(negedge core_clk_i);
        chk("active", 8'h00, {7'h0, act[3]});
        wr(8'h23, 8'h00);
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        write_i = 1'b0;
        read_i = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_regs();
        t_cad(OSC_TONE1, 16'h0002, 8'h01);
        t_cad(OSC_TONE2, 16'h0001, 8'h03);
        t_cad(OSC_RING, 16'h0003, 8'h02);
        t_cad(OSC_METER, 16'h0100, 8'h02);
        t_noon();
        t_nooff();
        end_of_test();
    end
    // Hang guard, well past the expected run
    initial begin
        #3_000_000;
        error_cnt++;
        end_of_test();
    end
endmodule

// ---- test/tct_top_sva.sv ----
`timescale 1ns/100ps
module tct_top_sva
    import tct_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic tone1_active_o,
    input wire logic tone2_active_o,
    input wire logic ring_active_o,
    input wire logic meter_signal_active_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic meter_osc_reg;
    int run_reg;
    logic ctrl_wr;
    assign ctrl_wr = write_i && addr_i == PULSE_METER_CONTROL_OFS;

    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the meter oscillator bit
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meter_osc_reg <= 1'b0;
        end else if (ctrl_wr) begin
            meter_osc_reg <= wdata_i[CTRL_OSC_BIT];
        end
    end
    // Length of the current meter active run
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_reg <= 0;
        end else begin
            run_reg <= meter_signal_active_o ? run_reg + 1 : 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(read_i) |-> rdata_o == READ_ZERO)
        else $error("read data not idle");
    status_mirror_a: assert property ($past(read_i && addr_i == PULSE_METER_CONTROL_OFS)
        |-> rdata_o[7] == $past(meter_signal_active_o)) else $error("status bit wrong");
    reserved_zero_a: assert property ($past(read_i && addr_i == PULSE_METER_CONTROL_OFS)
        |-> rdata_o[6:5] == 2'h0 && rdata_o[1:0] == 2'h0) else $error("reserved bits set");
    osc_start_a: assert property (ctrl_wr && wdata_i[2] && !meter_osc_reg
        |-> ##[2:3] meter_signal_active_o) else $error("meter did not start");
    osc_stop_a: assert property (ctrl_wr && !wdata_i[2] |-> ##2 !meter_signal_active_o)
        else $error("meter did not stop");
    osc_gate_a: assert property (meter_signal_active_o |-> meter_osc_reg || $past(meter_osc_reg))
        else $error("meter active while off");
    on_min_a: assert property (disable iff (!nrst_i || write_i)
        $rose(tone1_active_o) |-> tone1_active_o[*4]) else $error("tone1 active too short");
    off_min_a: assert property (disable iff (!nrst_i || write_i)
        $fell(ring_active_o) |-> !ring_active_o[*4]) else $error("ring inactive too short");
    tick_multiple_a: assert property ($fell(meter_signal_active_o) && !$past(write_i)
        && !$past(write_i, 2) && !$past(write_i, 3) |-> run_reg % TICK_LEN == 0)
        else $error("meter run not whole ticks");
    cover property ($rose(meter_signal_active_o));
    cover property ($fell(tone2_active_o));
    cover property (read_i && addr_i == PULSE_METER_CONTROL_OFS);
endmodule

bind tct_top tct_top_sva #(.TICK_LEN(TICK_LEN)) u_sva (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .tone1_active_o(tone1_active_o), .tone2_active_o(tone2_active_o), .ring_active_o(ring_active_o),
    .meter_signal_active_o(meter_signal_active_o));
